// ===== hdl/derio_top.sv
// deposition event relay, indexer handshake and analog scaling block
// Notes on behaviour
// - analog channels span plus or minus ten volts
// - display value is volts times gain plus offset
// - unity gain, zero offset reports plain volts
// - completion enabled: missing completion before timeout halts
// - completion disabled: wait fixed delay, then start
// - test move commands chosen indexer to position
// - sixteen relays map onto two output banks
// - twelve inputs map in order to points
// - each relay energised while assigned event active
// - source shutter relay follows its deposit phase
// - single mode: relay takes layer sensor enable at film start and holds it
// - dual mode: primary sensor relay open in use
// - dual mode: primary (even) crystal failure closes its relay until film end
// - test set closes, test clear opens relay
`timescale 1ns/10ps
module derio_top #(
	parameter int TICK_CYC = derio_pkg::TICK_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	input wire derio_pkg::derio_proc_t proc_i,
	input wire logic [11:0] din_i,
	input wire logic idx_done_i,
	input wire logic [3:0][15:0] ana_i,
	output derio_pkg::derio_idx_t idx_o,
	output logic layer_go_o,
	output logic halt_o,
	output logic [15:0] relay_o
);
	localparam int IRQ_W_L = derio_pkg::IRQ_W;
	derio_pkg::derio_st_t q;
	derio_pkg::derio_st_t d;
	derio_pkg::derio_ana_t ana;
	derio_pkg::derio_res_t res;
	logic acc;
	logic wr;
	logic tick;
	logic done_rise;
	logic xgood;
	logic xfail_all;
	logic [11:0] agree;
	logic [IRQ_W_L-1:0] ev;
	logic [31:0] w;
	logic [31:0] r;
	logic start;
	logic st_layer;
	logic [3:0] st_idx;
	logic [7:0] st_pos;

	function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// event code to level; unknown codes leave the relay open
	function automatic logic ev_active(input logic [4:0] code, input logic [5:0] dep,
			input logic [7:0] sens, input logic xg, input logic xf, input logic hlt);
		logic a;
		a = 1'b0;
		if (code >= derio_pkg::EV_SRC_BASE && code < derio_pkg::EV_SENS_BASE) begin
			a = dep[3'(code - derio_pkg::EV_SRC_BASE)];
		end else if (code >= derio_pkg::EV_SENS_BASE && code < derio_pkg::EV_DEPOSIT) begin
			a = sens[3'(code - derio_pkg::EV_SENS_BASE)];
		end else if (code == derio_pkg::EV_DEPOSIT) begin
			a = |dep;
		end else if (code == derio_pkg::EV_XGOOD) begin
			a = xg;
		end else if (code == derio_pkg::EV_XFAIL) begin
			a = xf;
		end else if (code == derio_pkg::EV_HALT) begin
			a = hlt;
		end
		return a;
	endfunction

	derio_scale u_scale (
		.clk(clk),
		.rst_b(rst_b),
		.in_i(ana),
		.res_o(res)
	);

	always_comb begin
		d = q;
		d.wb_ack = 1'b0;
		d.idx.move = 1'b0;
		d.layer_go = 1'b0;
		ev = '0;
		r = 32'h0000_0000;
		acc = wb_cyc_i & wb_stb_i & ~q.wb_ack;
		// a write takes effect on the edge where the master sees ack
		wr = wb_cyc_i & wb_stb_i & wb_we_i & q.wb_ack;
		w = 32'h0000_0000;
		tick = (q.tick_cnt == 19'(TICK_CYC - 1));
		d.tick_cnt = tick ? 19'h0_0000 : q.tick_cnt + 19'h0_0001;

		// analog channels scanned round robin; each reading is a signed
		// full scale code of +/-10 V, one scaled result per clock
		ana.vld = 1'b1;
		ana.ch = q.ana_ch;
		ana.x = ana_i[q.ana_ch];
		ana.gain = q.gain[q.ana_ch];
		ana.offs = q.offs[q.ana_ch];
		d.ana_ch = q.ana_ch + 2'h1;
		if (res.vld) begin
			d.res[res.ch] = res.y;
		end

		// pins pass three flops; a change counts once stages two and three agree
		d.din_s1 = din_i;
		d.din_s2 = q.din_s1;
		d.din_s3 = q.din_s2;
		agree = ~(q.din_s2 ^ q.din_s3);
		d.din = (agree & q.din_s3) | (~agree & q.din);
		ev[derio_pkg::IRQ_INCHG] = |(d.din ^ q.din);
		d.done_s = {q.done_s[1:0], idx_done_i};
		if (q.done_s[1] == q.done_s[2]) begin
			d.done = q.done_s[2];
		end
		done_rise = d.done & ~q.done;

		// bus read data, latched at request so it stands while ack is high
		case (wb_adr_i)
			derio_pkg::A_CTRL: r = {29'h0, q.lyr_cmp, q.src_cmp, q.dual};
			derio_pkg::A_SRC_TMR: r = {16'h0000, q.src_tmr};
			derio_pkg::A_LYR_TMR: r = {16'h0000, q.lyr_tmr};
			derio_pkg::A_MOVE: r = {16'h0000, q.idx.pos, q.idx.idx, 3'h0, q.idx.layer};
			derio_pkg::A_STAT: r = {28'h0, q.stat};
			derio_pkg::A_MASK: r = {28'h0, q.mask};
			derio_pkg::A_TEST: r = {q.tst_val, q.tst_en};
			derio_pkg::A_INPUTS: r = {20'h0_0000, q.din};
			derio_pkg::A_MSTAT: r = {4'h0, q.sens, q.relay, 2'h0, q.halt, q.mv != derio_pkg::MV_IDLE};
			default: begin
				if (wb_adr_i[7:6] == derio_pkg::A_EVT_PG) begin
					r = {27'h0, q.evt[wb_adr_i[5:2]]};
				end else if (wb_adr_i[7:4] == derio_pkg::A_GAIN_PG) begin
					r = {16'h0000, q.gain[wb_adr_i[3:2]]};
				end else if (wb_adr_i[7:4] == derio_pkg::A_OFFS_PG) begin
					r = {16'h0000, q.offs[wb_adr_i[3:2]]};
				end else if (wb_adr_i[7:4] == derio_pkg::A_RES_PG) begin
					r = {16'h0000, q.res[wb_adr_i[3:2]]};
				end
			end
		endcase
		d.wb_ack = acc;
		if (acc) begin
			d.wb_dat = r;
		end

		start = q.mv == derio_pkg::MV_IDLE && proc_i.move_req;
		st_layer = proc_i.move_layer;
		st_idx = proc_i.move_idx;
		st_pos = proc_i.move_pos;
		if (wr) begin
			w = bmerge(r, wb_dat_i, wb_sel_i);
			case (wb_adr_i)
				derio_pkg::A_CTRL: begin
					d.dual = w[derio_pkg::CTRL_DUAL];
					d.src_cmp = w[derio_pkg::CTRL_SRC_CMP];
					d.lyr_cmp = w[derio_pkg::CTRL_LYR_CMP];
				end
				derio_pkg::A_SRC_TMR: d.src_tmr = w[15:0];
				derio_pkg::A_LYR_TMR: d.lyr_tmr = w[15:0];
				derio_pkg::A_MOVE: begin
					// manual move; refused while a move is in flight
					start = q.mv == derio_pkg::MV_IDLE;
					st_layer = w[derio_pkg::MV_LAYER];
					st_idx = w[derio_pkg::MV_IDX_LSB +: 4];
					st_pos = w[derio_pkg::MV_POS_LSB +: 8];
				end
				derio_pkg::A_STAT: d.stat = q.stat & ~wb_dat_i[IRQ_W_L-1:0];
				derio_pkg::A_MASK: d.mask = w[IRQ_W_L-1:0];
				derio_pkg::A_TEST: begin
					if (wb_dat_i[derio_pkg::TST_CLRALL]) begin
						d.tst_en = 16'h0000;
					end else if (wb_dat_i[derio_pkg::TST_SET]) begin
						d.tst_en[wb_dat_i[3:0]] = 1'b1;
						d.tst_val[wb_dat_i[3:0]] = 1'b1;
					end else if (wb_dat_i[derio_pkg::TST_CLR]) begin
						d.tst_en[wb_dat_i[3:0]] = 1'b1;
						d.tst_val[wb_dat_i[3:0]] = 1'b0;
					end
				end
				default: begin
					if (wb_adr_i[7:6] == derio_pkg::A_EVT_PG) begin
						d.evt[wb_adr_i[5:2]] = w[4:0];
					end else if (wb_adr_i[7:4] == derio_pkg::A_GAIN_PG) begin
						d.gain[wb_adr_i[3:2]] = w[15:0];
					end else if (wb_adr_i[7:4] == derio_pkg::A_OFFS_PG) begin
						d.offs[wb_adr_i[3:2]] = w[15:0];
					end
				end
			endcase
		end

		// indexer move; timer counts 10 ms ticks of a free divider, so the
		// wait is accurate to one tick
		case (q.mv)
			derio_pkg::MV_IDLE: begin
				if (start) begin
					d.idx.move = 1'b1;
					d.idx.layer = st_layer;
					d.idx.idx = st_idx;
					d.idx.pos = st_pos;
					d.halt = 1'b0;
					d.mv_cnt = st_layer ? q.lyr_tmr : q.src_tmr;
					if (st_layer ? q.lyr_cmp : q.src_cmp) begin
						d.mv = derio_pkg::MV_WAIT_DONE;
					end else begin
						d.mv = derio_pkg::MV_WAIT_TMR;
					end
				end
			end
			derio_pkg::MV_WAIT_DONE: begin
				if (done_rise) begin
					d.layer_go = 1'b1;
					ev[derio_pkg::IRQ_DONE] = 1'b1;
					d.mv = derio_pkg::MV_IDLE;
				end else if (tick) begin
					if (q.mv_cnt == 16'h0000) begin
						d.halt = 1'b1;
						ev[derio_pkg::IRQ_TMO] = 1'b1;
						d.mv = derio_pkg::MV_IDLE;
					end else begin
						d.mv_cnt = q.mv_cnt - 16'h0001;
					end
				end
			end
			derio_pkg::MV_WAIT_TMR: begin
				if (tick) begin
					if (q.mv_cnt == 16'h0000) begin
						d.layer_go = 1'b1;
						ev[derio_pkg::IRQ_DONE] = 1'b1;
						d.mv = derio_pkg::MV_IDLE;
					end else begin
						d.mv_cnt = q.mv_cnt - 16'h0001;
					end
				end
			end
			default: d.mv = derio_pkg::MV_IDLE;
		endcase

		// sensor shutters
		d.xf_prev = proc_i.xtal_fail;
		ev[derio_pkg::IRQ_XFAIL] = |(proc_i.xtal_fail & ~q.xf_prev & proc_i.sens_en);
		if (proc_i.film_start) begin
			d.film_act = 1'b1;
			// dual mode starts each film on primaries with all relays open
			d.sens = q.dual ? 8'h00 : proc_i.sens_en;
		end else if (proc_i.film_end) begin
			d.film_act = 1'b0;
			if (q.dual) begin
				d.sens = 8'h00;
			end
		end else if (q.dual && q.film_act) begin
			for (int i = 0; i < derio_pkg::NSENS; i += 2) begin
				if (proc_i.xtal_fail[i] && proc_i.sens_en[i]) begin
					d.sens[i] = 1'b1;
				end
			end
		end
		xgood = (proc_i.sens_en != 8'h00) && ((proc_i.sens_en & proc_i.xtal_fail) == 8'h00);
		xfail_all = (proc_i.sens_en != 8'h00) && ((proc_i.sens_en & ~proc_i.xtal_fail) == 8'h00);

		// relay n drives bank point n-1; bit 8 onward is the second bank
		for (int i = 0; i < derio_pkg::NRELAY; i++) begin
			if (q.tst_en[i]) begin
				d.relay[i] = q.tst_val[i];
			end else begin
				d.relay[i] = ev_active(q.evt[i], proc_i.deposit, q.sens, xgood, xfail_all,
					q.halt);
			end
		end

		// set wins over a clear in the same cycle
		d.stat = d.stat | ev;
		d.irq = |(d.stat & d.mask);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '0;
			q.src_tmr <= derio_pkg::TMR_RST;
			q.lyr_tmr <= derio_pkg::TMR_RST;
			q.gain <= {4{derio_pkg::GAIN_ONE}};
			q.offs <= {4{derio_pkg::OFFS_ZERO}};
			q.mv <= derio_pkg::MV_IDLE;
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o = q.wb_dat;
	assign wb_ack_o = q.wb_ack;
	assign irq_o = q.irq;
	assign idx_o = q.idx;
	assign layer_go_o = q.layer_go;
	assign halt_o = q.halt;
	assign relay_o = q.relay;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_reset_open;
		$rose(rst_b) |-> (relay_o == 16'h0000 && !halt_o);
	endproperty
	a_reset_open: assert property (p_reset_open) else $error("relays not open after reset");

	property p_src_shutter;
		(q.evt[0] == derio_pkg::EV_SRC_BASE && !q.tst_en[0]) |=> relay_o[0] == $past(proc_i.deposit[0]);
	endproperty
	a_src_shutter: assert property (p_src_shutter) else $error("shutter relay missed deposit");

	property p_timeout;
		(q.mv == derio_pkg::MV_WAIT_DONE && tick && q.mv_cnt == 16'h0000 && !done_rise)
			|=> (halt_o && !layer_go_o && q.mv == derio_pkg::MV_IDLE);
	endproperty
	a_timeout: assert property (p_timeout) else $error("move timeout did not halt");

	property p_fixed_delay;
		(q.mv == derio_pkg::MV_WAIT_TMR && tick && q.mv_cnt == 16'h0000) |=> (layer_go_o && !halt_o)
			##1 !layer_go_o;
	endproperty
	a_fixed_delay: assert property (p_fixed_delay) else $error("fixed delay did not start layer");

	property p_move_cmd;
		(q.mv == derio_pkg::MV_IDLE && proc_i.move_req && !(wr && wb_adr_i == derio_pkg::A_MOVE))
			|=> (idx_o.move && idx_o.pos == $past(proc_i.move_pos) && q.mv != derio_pkg::MV_IDLE);
	endproperty
	a_move_cmd: assert property (p_move_cmd) else $error("indexer not commanded");

	property p_test_set;
		(wr && wb_adr_i == derio_pkg::A_TEST && wb_dat_i[derio_pkg::TST_SET] &&
			!wb_dat_i[derio_pkg::TST_CLRALL]) |-> ##2 relay_o[$past(wb_dat_i[3:0], 2)];
	endproperty
	a_test_set: assert property (p_test_set) else $error("test set left relay open");

	property p_single_sens;
		(!q.dual && proc_i.film_start) |=> q.sens == $past(proc_i.sens_en);
	endproperty
	a_single_sens: assert property (p_single_sens) else $error("sensor relays not updated");

	property p_dual_open;
		(q.dual && proc_i.film_start) |=> q.sens == 8'h00;
	endproperty
	a_dual_open: assert property (p_dual_open) else $error("primary relay closed at film start");

	property p_dual_fail;
		(q.dual && q.film_act && proc_i.xtal_fail[0] && proc_i.sens_en[0] && !proc_i.film_end &&
			!proc_i.film_start) |=> q.sens[0] ##1 (q.sens[0] || $past(proc_i.film_end));
	endproperty
	a_dual_fail: assert property (p_dual_fail) else $error("failed sensor relay not held");
endmodule

// ===== hdl/derio_pkg.sv
// constants, register map and carrier types of the deposition event relay block
package derio_pkg;
	localparam int CLK_NS = 20;
	localparam int TICK_NS = 10000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam logic [15:0] TMR_RST = 16'h03E8;
	localparam logic [15:0] GAIN_ONE = 16'h0100;
	localparam logic [15:0] OFFS_ZERO = 16'h0000;
	localparam int NRELAY = 16;
	localparam int NIN = 12;
	localparam int NSRC = 6;
	localparam int NSENS = 8;
	localparam int NANA = 4;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_SRC_TMR = 8'h04;
	localparam logic [7:0] A_LYR_TMR = 8'h08;
	localparam logic [7:0] A_MOVE = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_MASK = 8'h14;
	localparam logic [7:0] A_TEST = 8'h18;
	localparam logic [7:0] A_INPUTS = 8'h1C;
	localparam logic [7:0] A_MSTAT = 8'h20;
	localparam logic [1:0] A_EVT_PG = 2'h1;
	localparam logic [3:0] A_GAIN_PG = 4'h8;
	localparam logic [3:0] A_OFFS_PG = 4'h9;
	localparam logic [3:0] A_RES_PG = 4'hA;
	localparam int CTRL_DUAL = 0;
	localparam int CTRL_SRC_CMP = 1;
	localparam int CTRL_LYR_CMP = 2;
	localparam int MV_LAYER = 0;
	localparam int MV_IDX_LSB = 4;
	localparam int MV_POS_LSB = 8;
	localparam int TST_SET = 8;
	localparam int TST_CLR = 9;
	localparam int TST_CLRALL = 10;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_TMO = 1;
	localparam int IRQ_XFAIL = 2;
	localparam int IRQ_INCHG = 3;
	localparam int IRQ_W = 4;
	localparam logic [4:0] EV_NONE = 5'h00;
	localparam logic [4:0] EV_SRC_BASE = 5'h01;
	localparam logic [4:0] EV_SENS_BASE = 5'h07;
	localparam logic [4:0] EV_DEPOSIT = 5'h0F;
	localparam logic [4:0] EV_XGOOD = 5'h10;
	localparam logic [4:0] EV_XFAIL = 5'h11;
	localparam logic [4:0] EV_HALT = 5'h12;

	typedef enum logic [1:0] {MV_IDLE, MV_WAIT_DONE, MV_WAIT_TMR} derio_mv_t;

	typedef struct packed {
		logic film_start;
		logic film_end;
		logic move_req;
		logic move_layer;
		logic [3:0] move_idx;
		logic [7:0] move_pos;
		logic [5:0] deposit;
		logic [7:0] sens_en;
		logic [7:0] xtal_fail;
	} derio_proc_t;

	typedef struct packed {
		logic move;
		logic layer;
		logic [3:0] idx;
		logic [7:0] pos;
	} derio_idx_t;

	typedef struct packed {
		logic vld;
		logic [1:0] ch;
		logic [15:0] x;
		logic [15:0] gain;
		logic [15:0] offs;
	} derio_ana_t;

	typedef struct packed {
		logic vld;
		logic [1:0] ch;
		logic [15:0] y;
	} derio_res_t;

	typedef struct packed {
		logic wb_ack;
		logic [31:0] wb_dat;
		logic dual;
		logic src_cmp;
		logic lyr_cmp;
		logic [15:0] src_tmr;
		logic [15:0] lyr_tmr;
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] mask;
		logic irq;
		logic [15:0] tst_en;
		logic [15:0] tst_val;
		logic [15:0][4:0] evt;
		logic [3:0][15:0] gain;
		logic [3:0][15:0] offs;
		logic [3:0][15:0] res;
		logic [1:0] ana_ch;
		logic [11:0] din_s1;
		logic [11:0] din_s2;
		logic [11:0] din_s3;
		logic [11:0] din;
		logic [2:0] done_s;
		logic done;
		derio_mv_t mv;
		logic [15:0] mv_cnt;
		logic [18:0] tick_cnt;
		derio_idx_t idx;
		logic layer_go;
		logic halt;
		logic [7:0] sens;
		logic [7:0] xf_prev;
		logic film_act;
		logic [15:0] relay;
	} derio_st_t;
endpackage

// ===== hdl/derio_scale.sv
// linear scaling of one analog reading: volts x gain + offset
`timescale 1ns/10ps
module derio_scale (
	input wire logic clk,
	input wire logic rst_b,
	input wire derio_pkg::derio_ana_t in_i,
	output derio_pkg::derio_res_t res_o
);
	derio_pkg::derio_res_t q;
	derio_pkg::derio_res_t d;
	logic signed [31:0] prod;
	logic signed [32:0] sum;

	// gain is signed 8.8 fixed point, so 16'h0100 is unity
	always_comb begin
		prod = $signed(in_i.x) * $signed(in_i.gain);
		sum = 33'(prod >>> 8) + 33'($signed(in_i.offs));
		d.vld = in_i.vld;
		d.ch = in_i.ch;
		// saturate instead of wrapping so a large gain cannot flip the sign
		if (sum > 33'sh0_0000_7FFF) begin
			d.y = 16'h7FFF;
		end else if (sum < -33'sh0_0000_8000) begin
			d.y = 16'h8000;
		end else begin
			d.y = sum[15:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign res_o = q;

	property p_unity;
		@(posedge clk) disable iff (!rst_b)
		(in_i.vld && in_i.gain == derio_pkg::GAIN_ONE && in_i.offs == derio_pkg::OFFS_ZERO)
			|=> (q.y == $past(in_i.x) && q.ch == $past(in_i.ch));
	endproperty
	a_unity: assert property (p_unity) else $error("unity scaling changed the reading");
endmodule

// ===== test/derio_idx_model.sv
// indexer model: answers each commanded move with a completion level in prompt or slow mode; the silent mode never answers
`timescale 1ns/10ps
module derio_idx_model (
	input wire logic clk,
	input wire derio_pkg::derio_idx_t idx_i,
	input wire logic [1:0] mode,
	output logic done_o
);
	int cnt = -1;
	initial done_o = 1'b0;
	// mode 0 prompt, 1 slow, 2 silent; the silent indexer exists only to provoke the timeout
	always @(posedge clk) begin
		if (idx_i.move) begin
			done_o <= 1'b0;
			cnt <= (mode == 2'h0) ? 4 : (mode == 2'h1) ? 25 : -1;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end else if (cnt == 0) begin
			done_o <= 1'b1;
			cnt <= -1;
		end
	end
endmodule

// ===== test/derio_tb_top.sv
// self-checking bench of the deposition event relay block
`timescale 1ns/10ps
module derio_tb_top;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack, irq, done, layer_go, halt;
	logic [15:0] relay;
	logic [11:0] din = 12'h000;
	logic [3:0][15:0] ana = {16'h1234, 16'hF00D, 16'h8001, 16'h7FFF};
	logic [1:0] idx_mode = 2'h0;
	derio_pkg::derio_proc_t proc = '0;
	derio_pkg::derio_idx_t idx;
	int err_total = 0;
	int n_compared = 0;

	always #10 clk = ~clk;

	// short tick keeps the 10 ms timer units within a few dozen cycles
	derio_top #(.TICK_CYC(10)) u_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq_o(irq), .proc_i(proc), .din_i(din), .idx_done_i(done),
		.ana_i(ana), .idx_o(idx), .layer_go_o(layer_go), .halt_o(halt), .relay_o(relay));
	derio_idx_model u_idx (.clk(clk), .idx_i(idx), .mode(idx_mode), .done_o(done));

	task automatic tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = rdat;
		if (k >= 50) err_total++;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		sel <= 4'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		wb(1'b0, a, 32'h0, q);
	endtask

	// sel 0 move pulse, 1 layer start, 2 halt; n counts edges until seen
	task automatic wait_ev(input int sel, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(sel == 0 ? idx.move === 1'b1 : sel == 1 ? layer_go === 1'b1 :
			halt === 1'b1) && n < 300);
		if (n >= 300) err_total++;
	endtask

	task automatic pulse_film(input logic start);
		if (start) proc.film_start <= 1'b1;
		else proc.film_end <= 1'b1;
		@(posedge clk);
		proc.film_start <= 1'b0;
		proc.film_end <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	function automatic logic [15:0] scale_exp(input logic [15:0] x, input logic [15:0] g,
		input logic [15:0] o);
		int v;
		v = (int'($signed(x)) * int'($signed(g))) / 256 + int'($signed(o));
		if (v > 32767) v = 32767;
		if (v < -32768) v = -32768;
		return 16'(v);
	endfunction

	function automatic logic [15:0] src_exp(input logic [5:0] dep);
		logic [15:0] e;
		for (int r = 0; r < 16; r++) e[r] = dep[r % 6];
		return e;
	endfunction

	initial begin
		#1000000;
		err_total++;
		tally_and_finish;
	end

	initial begin
		logic [31:0] v;
		logic [3:0][15:0] g, o;
		logic [7:0] se;
		int n;
		v = $urandom(12869);
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		check(relay, 16'h0000);
		rd(derio_pkg::A_LYR_TMR, v);
		check(v, {16'h0, derio_pkg::TMR_RST});
		rd(8'hFC, v);
		check(v, 32'h0);
		repeat (12) @(posedge clk);
		for (int c = 0; c < 4; c++) begin
			rd({derio_pkg::A_RES_PG, 2'(c), 2'b00}, v);
			check(v, {16'h0, ana[c]});
		end
		for (int c = 0; c < 4; c++) begin
			g[c] = 16'((int'($urandom_range(0, 3)) - 1) * 256);
			o[c] = 16'(int'($urandom_range(0, 2000)) - 1000);
			wr({derio_pkg::A_GAIN_PG, 2'(c), 2'b00}, {16'h0, g[c]});
			wr({derio_pkg::A_OFFS_PG, 2'(c), 2'b00}, {16'h0, o[c]});
		end
		ana[3] <= 16'($urandom);
		repeat (12) @(posedge clk);
		for (int c = 0; c < 4; c++) begin
			rd({derio_pkg::A_RES_PG, 2'(c), 2'b00}, v);
			check(v, {16'h0, scale_exp(ana[c], g[c], o[c])});
		end
		din <= 12'($urandom);
		repeat (6) @(posedge clk);
		rd(derio_pkg::A_INPUTS, v);
		check(v, {20'h0, din});
		for (int r = 0; r < 16; r++) wr({derio_pkg::A_EVT_PG, 4'(r), 2'b00}, 32'(r % 6 + 1));
		for (int i = 0; i < 4; i++) begin
			proc.deposit <= (i == 3) ? 6'h3F : 6'($urandom);
			repeat (3) @(posedge clk);
			check(relay, src_exp(proc.deposit));
		end
		wr(derio_pkg::A_TEST, 32'h20F);
		repeat (3) @(posedge clk);
		check(relay, 16'h7FFF);
		proc.deposit <= 6'h00;
		wr(derio_pkg::A_TEST, 32'h10F);
		repeat (3) @(posedge clk);
		check(relay, 16'h8000);
		proc.deposit <= 6'h08;
		wr(derio_pkg::A_TEST, 32'h400);
		repeat (3) @(posedge clk);
		check(relay, src_exp(6'h08));
		for (int r = 0; r < 8; r++) wr({derio_pkg::A_EVT_PG, 4'(r), 2'b00}, 32'(r + 7));
		se = 8'($urandom);
		proc.sens_en <= se;
		pulse_film(1'b1);
		check(relay[7:0], se);
		proc.sens_en <= ~se;
		repeat (4) @(posedge clk);
		check(relay[7:0], se);
		wr(derio_pkg::A_CTRL, 32'h1);
		proc.sens_en <= 8'hFF;
		pulse_film(1'b1);
		check(relay[7:0], 8'h00);
		proc.xtal_fail <= 8'h0D;
		repeat (4) @(posedge clk);
		check(relay[7:0], 8'h05);
		wr(derio_pkg::A_MASK, 32'h4);
		repeat (2) @(posedge clk);
		check(irq, 1'b1);
		wr(derio_pkg::A_STAT, 32'h4);
		proc.xtal_fail <= 8'h00;
		repeat (4) @(posedge clk);
		check({irq, relay[7:0]}, 9'h005);
		pulse_film(1'b0);
		check(relay[7:0], 8'h00);
		wr(derio_pkg::A_CTRL, 32'h0);
		wr(derio_pkg::A_LYR_TMR, 32'h3);
		wr(derio_pkg::A_MOVE, 32'h5A21);
		wait_ev(0, n);
		check({idx.layer, idx.idx, idx.pos}, {1'b1, 4'h2, 8'h5A});
		wait_ev(1, n);
		check(32'(n >= 28 && n <= 45), 32'h1);
		wr(derio_pkg::A_CTRL, 32'h6);
		proc.move_layer <= 1'b0;
		proc.move_idx <= 4'hF;
		proc.move_pos <= 8'($urandom);
		proc.move_req <= 1'b1;
		@(posedge clk);
		proc.move_req <= 1'b0;
		wait_ev(0, n);
		check({idx.layer, idx.idx, idx.pos}, {1'b0, 4'hF, proc.move_pos});
		wait_ev(1, n);
		check({halt, 7'(n <= 25)}, 8'h01);
		idx_mode <= 2'h2;
		wr(derio_pkg::A_MOVE, 32'h0131);
		wait_ev(0, n);
		wait_ev(2, n);
		check(32'(n >= 28 && n <= 45), 32'h1);
		rd(derio_pkg::A_STAT, v);
		check(v[1], 1'b1);
		// relays 9 to 12 on any deposit, all good, all failed and halted while halted
		for (int r = 8; r < 12; r++) wr({derio_pkg::A_EVT_PG, 4'(r), 2'b00}, 32'(r + 7));
		repeat (2) @(posedge clk);
		check(relay[11:8], 4'hB);
		proc.xtal_fail <= 8'hFF;
		repeat (3) @(posedge clk);
		check(relay[11:8], 4'hD);
		idx_mode <= 2'h1;
		wr(derio_pkg::A_MOVE, 32'h0231);
		wait_ev(0, n);
		repeat (2) @(posedge clk);
		check(halt, 1'b0);
		wait_ev(1, n);
		check(halt, 1'b0);
		tally_and_finish;
	end
endmodule
